/* File: verilog/uart_cpu_bus_interface.sv */
// cpu parallel bus port of the uart: selects, strobes, address latch, data bus
// Behaviour
// R1: three register-select bits choose the register each read or write targets.
// R2: selected only while both high selects are 1 and low select is 0.
// R3: read needs low read strobe at 0 or high read strobe at 1; data driven.
// R4: write needs either write strobe; the strobe's assertion edge makes the write event.
// R5: falling address strobe captures selects and register-select bits, held meanwhile.
// R6: host may tie address strobe low; selects and address then decode directly.
// R7: eight-bit data bus driven only during a valid read, otherwise released.
// R8: data bit zero is the byte's least significant bit, first on the line.
// R9: drive-disable output is low for as long as the cpu reads.
// R10: low read strobe at 0 reads, low write strobe at 0 writes.
// R11: host never mixes read and write strobes; keeps data stable at write end.
`timescale 1ns/1ps
module uart_cpu_bus_interface
  import host_port_pkg::*;
#(
  parameter int ADDR_WIDTH = host_port_pkg::ADDR_W,
  parameter int DATA_WIDTH = host_port_pkg::DATA_W
) (
  // clocking and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic clk_en,
  // cpu select and address pins
  input wire logic [ADDR_WIDTH-1:0] reg_select_bits,
  input wire logic select_high_a,
  input wire logic select_high_b,
  input wire logic select_low,
  input wire logic addr_latch_strobe_n,
  // cpu strobe pins
  input wire logic read_strobe_high,
  input wire logic read_strobe_low,
  input wire logic write_strobe_high,
  input wire logic write_strobe_low,
  // cpu data bus as three signals
  input wire logic [DATA_WIDTH-1:0] host_data_bus_in,
  output logic [DATA_WIDTH-1:0] host_data_bus_out,
  output logic host_data_bus_oe,
  output logic drive_disable_n,
  // internal register file side
  output logic [ADDR_WIDTH-1:0] reg_addr,
  output logic [DATA_WIDTH-1:0] reg_wdata,
  output logic reg_wr_pulse,
  output logic reg_rd_pulse,
  input wire logic [DATA_WIDTH-1:0] reg_rdata
);
  import host_port_pkg::*;

  localparam int SYNC_W = host_port_pkg::CTRL_W + ADDR_WIDTH + DATA_WIDTH;
  localparam logic [SYNC_W-1:0] SYNC_RST = {host_port_pkg::CTRL_RST, {(ADDR_WIDTH + DATA_WIDTH){1'b0}}};

  initial
  begin
    if (ADDR_WIDTH != host_port_pkg::ADDR_W) $error("uart_cpu_bus_interface: ADDR_WIDTH must be 3");
    if (DATA_WIDTH != host_port_pkg::DATA_W) $error("uart_cpu_bus_interface: DATA_WIDTH must be 8");
  end

  // pins in; active-low ones inverted so that 1 always means asserted
  logic [CTRL_W-1:0] ctrl_pins;
  logic [SYNC_W-1:0] sync_vec;
  logic [CTRL_W-1:0] ctrl_s;
  logic [ADDR_WIDTH-1:0] addr_s;
  logic [DATA_WIDTH-1:0] data_s;

  assign ctrl_pins = {~addr_latch_strobe_n, ~write_strobe_low, write_strobe_high, ~read_strobe_low,
                      read_strobe_high, ~select_low, select_high_b, select_high_a};

  pin_sync2 #(
    .WIDTH(SYNC_W),
    .RST_VAL(SYNC_RST)
  ) u_pin_sync (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .clk_en(clk_en),
    .async_in({ctrl_pins, reg_select_bits, host_data_bus_in}),
    .sync_out(sync_vec)
  );

  assign ctrl_s = sync_vec[SYNC_W-1 -: CTRL_W];
  assign addr_s = sync_vec[DATA_WIDTH +: ADDR_WIDTH];
  assign data_s = sync_vec[DATA_WIDTH-1:0];

  // chip-select decode of the live selects; the latch holds its result
  function automatic logic chip_selected(input logic sel_a, input logic sel_b, input logic sel_low_act);
    chip_selected = sel_a & sel_b & sel_low_act;
  endfunction

  // address latch state
  logic as_low_d_r;
  logic as_low_d_nxt;
  logic hold_r;
  logic hold_nxt;
  logic [ADDR_WIDTH-1:0] held_addr_r;
  logic [ADDR_WIDTH-1:0] held_addr_nxt;
  logic held_sel_r;
  logic held_sel_nxt;
  logic as_fall;
  logic live_sel;
  logic sel_eff;
  logic [ADDR_WIDTH-1:0] addr_eff;

  // the latch is edge triggered: with the strobe tied low from reset no edge
  // ever comes, so decoding stays on the live pins
  always_comb
  begin
    live_sel = chip_selected(ctrl_s[CB_SEL_A], ctrl_s[CB_SEL_B], ctrl_s[CB_SEL_LOW]); // R2
    as_fall = ctrl_s[CB_AS_LOW] & ~as_low_d_r; // R5
    as_low_d_nxt = ctrl_s[CB_AS_LOW];
    hold_nxt = ctrl_s[CB_AS_LOW] & (hold_r | as_fall); // R5 R6
    held_addr_nxt = as_fall ? addr_s : held_addr_r; // R5
    held_sel_nxt = as_fall ? live_sel : held_sel_r; // R5
    if (!clk_en)
    begin
      as_low_d_nxt = as_low_d_r;
      hold_nxt = hold_r;
      held_addr_nxt = held_addr_r;
      held_sel_nxt = held_sel_r;
    end
    sel_eff = hold_r ? held_sel_r : live_sel; // R6
    addr_eff = hold_r ? held_addr_r : addr_s; // R1 R6
  end

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      as_low_d_r <= AS_LOW_RST;
      hold_r <= HOLD_RST;
      held_addr_r <= '0;
      held_sel_r <= 1'b0;
    end
    else
    begin
      as_low_d_r <= as_low_d_nxt;
      hold_r <= hold_nxt;
      held_addr_r <= held_addr_nxt;
      held_sel_r <= held_sel_nxt;
    end
  end

  // access sequencer state
  port_state_t state_r;
  port_state_t state_nxt;
  logic rd_act;
  logic wr_act;
  logic [ADDR_WIDTH-1:0] addr_r;
  logic [ADDR_WIDTH-1:0] addr_nxt;
  logic [DATA_WIDTH-1:0] wdata_r;
  logic [DATA_WIDTH-1:0] wdata_nxt;
  logic [DATA_WIDTH-1:0] dout_r;
  logic [DATA_WIDTH-1:0] dout_nxt;
  logic wr_pulse_r;
  logic wr_pulse_nxt;
  logic rd_pulse_r;
  logic rd_pulse_nxt;
  logic oe_r;
  logic oe_nxt;
  logic drive_disable_n_n_r;
  logic drive_disable_n_n_nxt;

  // read wins if a misbehaving host raises both strobes at once
  always_comb
  begin
    rd_act = sel_eff & (ctrl_s[CB_RD_LOW] | ctrl_s[CB_RD_HIGH]); // R2 R3 R10
    wr_act = sel_eff & (ctrl_s[CB_WR_LOW] | ctrl_s[CB_WR_HIGH]); // R2 R4 R10
    state_nxt = state_r;
    addr_nxt = addr_r;
    wdata_nxt = wdata_r;
    dout_nxt = dout_r;
    wr_pulse_nxt = 1'b0;
    rd_pulse_nxt = 1'b0;
    case (state_r)
      ST_IDLE:
      begin
        addr_nxt = addr_eff; // R1
        if (rd_act)
        begin
          state_nxt = ST_READ;
          rd_pulse_nxt = 1'b1;
        end
        else if (wr_act)
        begin
          // write event on the assertion edge; bit 0 stays bit 0
          state_nxt = ST_WRITE;
          wr_pulse_nxt = 1'b1; // R4
          wdata_nxt = data_s; // R8
        end
      end
      ST_READ:
      begin
        dout_nxt = reg_rdata; // R3 R8
        if (!rd_act)
        begin
          state_nxt = ST_IDLE;
        end
      end
      ST_WRITE:
      begin
        if (!wr_act)
        begin
          state_nxt = ST_IDLE;
        end
      end
      default:
      begin
        state_nxt = ST_IDLE;
      end
    endcase
    // bus and drive-disable follow the read state; one flop each keeps them glitch free
    oe_nxt = (state_nxt == ST_READ); // R7
    drive_disable_n_n_nxt = ~(state_nxt == ST_READ); // R9
    if (!clk_en)
    begin
      state_nxt = state_r;
      addr_nxt = addr_r;
      wdata_nxt = wdata_r;
      dout_nxt = dout_r;
      wr_pulse_nxt = wr_pulse_r;
      rd_pulse_nxt = rd_pulse_r;
      oe_nxt = oe_r;
      drive_disable_n_n_nxt = drive_disable_n_n_r;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_r <= ST_IDLE;
      addr_r <= '0;
      wdata_r <= '0;
      dout_r <= '0;
      wr_pulse_r <= PULSE_RST;
      rd_pulse_r <= PULSE_RST;
      oe_r <= OE_RST;
      drive_disable_n_n_r <= DRIVE_DISABLE_N_N_RST;
    end
    else
    begin
      state_r <= state_nxt;
      addr_r <= addr_nxt;
      wdata_r <= wdata_nxt;
      dout_r <= dout_nxt;
      wr_pulse_r <= wr_pulse_nxt;
      rd_pulse_r <= rd_pulse_nxt;
      oe_r <= oe_nxt;
      drive_disable_n_n_r <= drive_disable_n_n_nxt;
    end
  end

  // outputs straight from flops
  assign host_data_bus_out = dout_r;
  assign host_data_bus_oe = oe_r;
  assign drive_disable_n = drive_disable_n_n_r;
  assign reg_addr = addr_r;
  assign reg_wdata = wdata_r;
  assign reg_wr_pulse = wr_pulse_r;
  assign reg_rd_pulse = rd_pulse_r;

  // checks
  a_drive_disable_n_tracks_oe: assert property (@(posedge ref_clk) disable iff (!rst_b)
    host_data_bus_oe == !drive_disable_n) else $error("drive disable not low exactly while bus driven"); // R9
  a_drive_only_read: assert property (@(posedge ref_clk) disable iff (!rst_b)
    host_data_bus_oe |-> state_r == ST_READ) else $error("data bus driven outside a read"); // R7
  a_read_starts: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (clk_en && state_r == ST_IDLE && rd_act) |=> host_data_bus_oe && reg_rd_pulse)
    else $error("read access did not drive the bus"); // R3
  a_read_ends: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (clk_en && state_r == ST_READ && !rd_act) |=> !host_data_bus_oe && drive_disable_n)
    else $error("bus still driven after read ended"); // R7
  a_write_single: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (reg_wr_pulse && clk_en) |=> !reg_wr_pulse) else $error("write event longer than one cycle"); // R4
  a_unselected_quiet: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (clk_en && state_r == ST_IDLE && !sel_eff) |=> !reg_wr_pulse && !reg_rd_pulse)
    else $error("access taken while not selected"); // R2
  a_latch_held: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (hold_r && ctrl_s[CB_AS_LOW]) |=> $stable(held_addr_r) && $stable(held_sel_r))
    else $error("latched address changed without a strobe edge"); // R5
  a_write_data_order: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (reg_wr_pulse && $past(clk_en)) |-> reg_wdata == $past(data_s))
    else $error("write data not taken bit for bit"); // R8
  a_write_address: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (reg_wr_pulse && $past(clk_en)) |-> reg_addr == $past(addr_eff))
    else $error("write address differs from decoded select bits"); // R1
  c_read_seen: cover property (@(posedge ref_clk) disable iff (!rst_b) reg_rd_pulse ##1 host_data_bus_oe);
  c_write_seen: cover property (@(posedge ref_clk) disable iff (!rst_b) reg_wr_pulse);
  c_latch_write: cover property (@(posedge ref_clk) disable iff (!rst_b) hold_r && reg_wr_pulse);
  c_back_to_back: cover property (@(posedge ref_clk) disable iff (!rst_b) reg_wr_pulse ##[1:20] reg_rd_pulse);
endmodule // uart_cpu_bus_interface

/* File: verilog/host_port_pkg.sv */
// constants and types shared by the cpu bus port of the uart
package host_port_pkg;
  localparam int ADDR_W = 3;
  localparam int DATA_W = 8;
  localparam int CTRL_W = 8;
  // reset values; active-low inputs are carried inverted (0 is idle), but the address strobe resets to 1 and drive-disable resets high
  localparam logic [CTRL_W-1:0] CTRL_RST = 8'h80;
  localparam logic DRIVE_DISABLE_N_N_RST = 1'b1;
  localparam logic OE_RST = 1'b0;
  localparam logic PULSE_RST = 1'b0;
  localparam logic HOLD_RST = 1'b0;
  localparam logic AS_LOW_RST = 1'b1;
  // control vector bit positions after synchronising
  localparam int CB_SEL_A = 0;
  localparam int CB_SEL_B = 1;
  localparam int CB_SEL_LOW = 2;
  localparam int CB_RD_HIGH = 3;
  localparam int CB_RD_LOW = 4;
  localparam int CB_WR_HIGH = 5;
  localparam int CB_WR_LOW = 6;
  localparam int CB_AS_LOW = 7;
  // access sequencer states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_READ = 2'b01,
    ST_WRITE = 2'b10
  } port_state_t;
endpackage

/* File: verilog/pin_sync2.sv */
// two-stage synchroniser for a vector of asynchronous pins
`timescale 1ns/1ps
module pin_sync2 #(
  parameter int WIDTH = 8,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  // clocking
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic clk_en,
  // pins in, synchronised out
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] meta_nxt;
  logic [WIDTH-1:0] sync_r;
  logic [WIDTH-1:0] sync_nxt;

  initial
  begin
    if (WIDTH < 1) $error("pin_sync2: WIDTH must be at least 1");
  end

  // first stage is read only by the second stage
  always_comb
  begin
    meta_nxt = clk_en ? async_in : meta_r;
    sync_nxt = clk_en ? meta_r : sync_r;
  end

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      meta_r <= RST_VAL;
      sync_r <= RST_VAL;
    end
    else
    begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
    end
  end

  assign sync_out = sync_r;
endmodule // pin_sync2

/* File: test/cpu_host_model.sv */
// cpu bus master model driving the uart host port pins
`timescale 1ns/1ps
module cpu_host_model (
  // clock and device outputs seen by the cpu
  input wire logic ref_clk,
  input wire logic [7:0] bus_out,
  input wire logic bus_oe,
  input wire logic drive_disable_n,
  // cpu pins: stb is rd_hi, rd_lo, wr_hi, wr_lo; cs is high a, high b, low
  output logic [2:0] rsel,
  output logic [2:0] cs,
  output logic as_n,
  output logic [3:0] stb,
  output logic [7:0] bus_in
);
  logic [7:0] drv;
  logic drv_en;
  logic [7:0] last;
  // no pull on the bus, so a released bus toggles rather than holding
  always_comb bus_in = bus_oe ? bus_out : (drv_en ? drv : ~last);
  always @(posedge ref_clk) last <= bus_in;
  // idle pins at time zero
  initial
  begin
    rsel = 3'h0;
    cs = 3'h1;
    as_n = 1'b0;
    stb = 4'h5;
    drv = 8'h00;
    drv_en = 1'b0;
    last = 8'h00;
  end
  // one strobe-timed access; pins settle before the strobe is raised
  task automatic access(input logic rd, input logic hi, input logic [2:0] a, input logic [2:0] c,
    input logic [7:0] d, output logic [7:0] q, output logic drove);
    @(posedge ref_clk);
    rsel <= a;
    cs <= c;
    drv <= d;
    drv_en <= !rd;
    repeat (4) @(posedge ref_clk);
    stb <= rd ? (hi ? 4'hd : 4'h1) : (hi ? 4'h7 : 4'h4);
    repeat (6) @(posedge ref_clk);
    #1;
    q = bus_in;
    drove = bus_oe & ~drive_disable_n;
    @(posedge ref_clk);
    stb <= 4'h5;
    repeat (5) @(posedge ref_clk);
    cs <= 3'h1;
    drv_en <= 1'b0;
  endtask
  // address strobe: lvl 0 latches the current pins, lvl 1 leaves it open
  task automatic strobe_as(input logic [2:0] a, input logic lvl);
    @(posedge ref_clk);
    rsel <= a;
    cs <= 3'h6;
    as_n <= 1'b1;
    repeat (4) @(posedge ref_clk);
    as_n <= lvl;
    repeat (4) @(posedge ref_clk);
  endtask
endmodule // cpu_host_model

/* File: test/uart_cpu_bus_interface_tb_top.sv */
// testbench for the uart cpu bus port
`timescale 1ns/1ps
module uart_cpu_bus_interface_tb_top;
  import host_port_pkg::*;
  logic ref_clk;
  logic rst_b;
  logic clk_en;
  logic [2:0] rsel;
  logic [2:0] cs;
  logic as_n;
  logic [3:0] stb;
  logic [7:0] bus_in;
  logic [7:0] bus_out;
  logic oe;
  logic drive_disable_n_n;
  logic [2:0] reg_addr;
  logic [7:0] reg_wdata;
  logic wr_p;
  logic rd_p;
  logic [7:0] regs [8];
  logic [2:0] wr_a;
  logic [7:0] wr_d;
  logic [7:0] q;
  logic dr;
  int n_errors;
  int checks;
  int wr_cnt;
  int rd_cnt;

  uart_cpu_bus_interface uart_cpu_bus_interface_i (
    .ref_clk(ref_clk), .rst_b(rst_b), .clk_en(clk_en),
    .reg_select_bits(rsel), .select_high_a(cs[2]), .select_high_b(cs[1]), .select_low(cs[0]),
    .addr_latch_strobe_n(as_n), .read_strobe_high(stb[3]), .read_strobe_low(stb[2]),
    .write_strobe_high(stb[1]), .write_strobe_low(stb[0]), .host_data_bus_in(bus_in),
    .host_data_bus_out(bus_out), .host_data_bus_oe(oe), .drive_disable_n(drive_disable_n_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr_pulse(wr_p), .reg_rd_pulse(rd_p),
    .reg_rdata(regs[reg_addr]));

  cpu_host_model cpu_host_model_i (
    .ref_clk(ref_clk), .bus_out(bus_out), .bus_oe(oe), .drive_disable_n(drive_disable_n_n),
    .rsel(rsel), .cs(cs), .as_n(as_n), .stb(stb), .bus_in(bus_in));

  initial
  begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  // register file behind the port; also logs each pulse
  always @(posedge ref_clk)
  begin
    if (wr_p === 1'b1)
    begin
      regs[reg_addr] <= reg_wdata;
      wr_a <= reg_addr;
      wr_d <= reg_wdata;
      wr_cnt <= wr_cnt + 1;
    end
    if (rd_p === 1'b1)
      rd_cnt <= rd_cnt + 1;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic t_write();
    int n0;
    for (int a = 0; a < 8; a++)
    begin
      n0 = wr_cnt;
      cpu_host_model_i.access(1'b0, a[0], 3'(a), 3'h6, 8'h01 << a, q, dr);
      chk(8'(wr_cnt - n0), 8'h01);
      chk({5'h0, wr_a}, 8'(a));
      chk(wr_d, 8'h01 << a);
      chk({7'h0, dr}, 8'h00);
    end
  endtask

  task automatic t_read();
    int n0;
    for (int a = 0; a < 8; a++)
    begin
      n0 = rd_cnt;
      cpu_host_model_i.access(1'b1, a[0], 3'(a), 3'h6, 8'h00, q, dr);
      chk(q, 8'h01 << a);
      chk({7'h0, dr}, 8'h01);
      chk(8'(rd_cnt - n0), 8'h01);
      chk({7'h0, oe}, 8'h00);
    end
  endtask

  // three wrong select combinations (3'h2, 3'h4, 3'h7) must each leave strobes without effect
  task automatic t_unsel();
    int w0;
    int r0;
    logic [2:0] bad [3];
    bad = '{3'h2, 3'h4, 3'h7};
    for (int i = 0; i < 3; i++)
    begin
      w0 = wr_cnt;
      r0 = rd_cnt;
      cpu_host_model_i.access(1'b0, 1'b1, 3'h0, bad[i], 8'hff, q, dr);
      cpu_host_model_i.access(1'b1, 1'b0, 3'h0, bad[i], 8'h00, q, dr);
      chk(8'(wr_cnt - w0), 8'h00);
      chk(8'(rd_cnt - r0), 8'h00);
      chk({7'h0, dr}, 8'h00);
    end
  endtask

  // latched address and selects outlive the pins changing
  task automatic t_latch();
    cpu_host_model_i.strobe_as(3'h3, 1'b0);
    cpu_host_model_i.access(1'b0, 1'b0, 3'h5, 3'h1, 8'ha5, q, dr);
    chk({5'h0, wr_a}, 8'h03);
    chk(wr_d, 8'ha5);
    cpu_host_model_i.strobe_as(3'h0, 1'b1);
    cpu_host_model_i.access(1'b1, 1'b1, 3'h3, 3'h6, 8'h00, q, dr);
    chk(q, 8'ha5);
    cpu_host_model_i.strobe_as(3'h0, 1'b0);
  endtask

  // a low clock enable must swallow a whole write; no stale event may fire on thaw
  task automatic t_freeze();
    int w0;
    w0 = wr_cnt;
    @(posedge ref_clk);
    clk_en <= 1'b0;
    cpu_host_model_i.access(1'b0, 1'b1, 3'h1, 3'h6, 8'h3c, q, dr);
    chk({7'h0, dr}, 8'h00);
    @(posedge ref_clk);
    clk_en <= 1'b1;
    repeat (4) @(posedge ref_clk);
    chk(8'(wr_cnt - w0), 8'h00);
    chk(regs[1], 8'h02);
  endtask

  task automatic close_out();
    $display("errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  initial
  begin
    rst_b = 1'b0;
    clk_en = 1'b1;
    n_errors = 0;
    checks = 0;
    wr_cnt = 0;
    rd_cnt = 0;
    foreach (regs[i])
      regs[i] = 8'h00;
    repeat (7) @(posedge ref_clk);
    #1;
    chk({7'h0, oe}, 8'h00);
    chk({7'h0, drive_disable_n_n}, 8'h01);
    @(posedge ref_clk);
    rst_b <= 1'b1;
    t_write();
    t_read();
    t_freeze();
    t_unsel();
    t_latch();
    close_out();
  end
endmodule // uart_cpu_bus_interface_tb_top
